// ==== logic/mmt_ctrl.sv ====
// apb register file and power, init and interrupt sequencing
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////

module mmt_ctrl #(
  parameter int unsigned ADDR_W    = 10,
  parameter int unsigned INIT_WAIT = mmt_pkg::INIT_LIMIT_CYC,
  parameter int unsigned WAKE_WAIT = mmt_pkg::WAKE_LIMIT_CYC,
  // identifier value is arbitrary
  parameter logic [7:0]  ID_CODE   = 8'h5a
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              module_reset_n,
  input  wire logic              low_power_request,
  input  wire logic [3:0]        rx_los,
  input  wire logic [3:0]        tx_fault,
  input  wire logic [47:0]       other_cond,
  output logic                   interrupt_request_n,
  output logic                   low_power_mode,
  output logic                   fully_functional,
  output logic                   serial_ready,
  output logic [7:0]             rate_select
);

  localparam int unsigned NF = mmt_pkg::NUM_FLAG_B * mmt_pkg::BYTE_W;
  localparam int unsigned CW = mmt_pkg::CNT_W;

  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_READY = 2'b01,
    ST_LOWPW = 2'b10
  } mmt_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic in_bank(input logic [7:0] idx,
                                   input logic [7:0] base);
    in_bank = (idx >= base) &&
              (idx < base + 8'(mmt_pkg::NUM_FLAG_B));
  endfunction : in_bank

  function automatic logic [2:0] bank_off(input logic [7:0] idx,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = idx - base;
    bank_off = d[2:0];
  endfunction : bank_off

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  mmt_state_t        state_r;
  mmt_state_t        state_nxt;
  mmt_pkg::mmt_ctrl_t ctrl_r;
  logic [NF-1:0]     mask_r;
  logic [NF-1:0]     flags;
  logic [NF-1:0]     flag_clr;
  logic [NF-1:0]     cond_all;
  logic [7:0]        page_r;
  logic [7:0]        idx;
  logic              pending;
  logic              dnr_r;
  logic              ready_evt_r;
  logic              wake_r;
  logic              in_reset_r;
  logic              pulse_done;
  logic              init_done;
  logic              lp_req;
  logic              wr_acc;
  logic              rd_acc;
  logic              setup;
  logic [31:0]       rd_nxt;
  logic              err_nxt;
  logic [CW-1:0]     init_limit;

  assign idx      = paddr[9:2];
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && pstrb[0] && !pslverr;
  assign rd_acc   = psel && penable && !pwrite && !pslverr;
  assign cond_all = {other_cond, tx_fault, rx_los};
  assign lp_req   = low_power_request || ctrl_r.pdown;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle

  assign pready = 1'b1;

  always_comb begin
    rd_nxt  = '0;
    err_nxt = 1'b0;
    if (idx == mmt_pkg::IDX_ID) begin
      rd_nxt[7:0] = ID_CODE;
    end else if (idx == mmt_pkg::IDX_STATUS) begin
      rd_nxt[mmt_pkg::STAT_DNR_BIT] = dnr_r;
      rd_nxt[mmt_pkg::STAT_LP_BIT]  = low_power_mode;
    end else if (in_bank(idx, mmt_pkg::IDX_FLAG_LO)) begin
      rd_nxt[7:0] = flags[8*bank_off(idx, mmt_pkg::IDX_FLAG_LO) +: 8];
    end else if (in_bank(idx, mmt_pkg::IDX_MASK_LO)) begin
      rd_nxt[7:0] = mask_r[8*bank_off(idx, mmt_pkg::IDX_MASK_LO) +: 8];
    end else if (idx == mmt_pkg::IDX_RATE) begin
      rd_nxt[7:0] = ctrl_r.rate;
    end else if (idx == mmt_pkg::IDX_PWR) begin
      rd_nxt[mmt_pkg::PWR_PD_BIT] = ctrl_r.pdown;
    end else if (idx == mmt_pkg::IDX_PAGE) begin
      rd_nxt[7:0] = page_r;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // data and error stand through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers

  // mask bytes at 100 to 106
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= {mmt_pkg::NUM_FLAG_B{mmt_pkg::MASK_RST}};
    end else if (wr_acc && in_bank(idx, mmt_pkg::IDX_MASK_LO)) begin
      mask_r[8*bank_off(idx, mmt_pkg::IDX_MASK_LO) +: 8] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.rate <= mmt_pkg::RATE_RST;
    end else if (wr_acc && idx == mmt_pkg::IDX_RATE) begin
      ctrl_r.rate <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.pdown <= 1'b0;
    end else if (wr_acc && idx == mmt_pkg::IDX_PWR) begin
      ctrl_r.pdown <= pwdata[mmt_pkg::PWR_PD_BIT];
    end
  end

  // page select only stored; upper pages live elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r <= mmt_pkg::PAGE_RST;
    end else if (wr_acc && idx == mmt_pkg::IDX_PAGE) begin
      page_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_select <= mmt_pkg::RATE_RST;
    end else begin
      rate_select <= ctrl_r.rate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags

  always_comb begin
    flag_clr = '0;
    if (rd_acc && in_bank(idx, mmt_pkg::IDX_FLAG_LO)) begin
      flag_clr[8*bank_off(idx, mmt_pkg::IDX_FLAG_LO) +: 8] = 8'hff;
    end
  end

  mmt_flags #(
    .N (NF)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (cond_all),
    .clr     (flag_clr),
    .mask    (mask_r),
    .flags   (flags),
    .pending (pending)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset pin filter

  // low for the minimum pulse is a reset
  mmt_timer #(
    .W (CW)
  ) u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (module_reset_n),
    .en      (!module_reset_n),
    .limit   (CW'(mmt_pkg::RST_PULSE_CYC)),
    .done    (pulse_done)
  );

  // shorter glitches never reach the limit and are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reset_r <= 1'b0;
    end else if (module_reset_n) begin
      in_reset_r <= 1'b0;
    end else if (pulse_done) begin
      in_reset_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // init and wake sequencing

  assign init_limit = wake_r ? CW'(WAKE_WAIT) : CW'(INIT_WAIT);

  // counting starts at the reset release
  mmt_timer #(
    .W (CW)
  ) u_init (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (in_reset_r || state_r != ST_INIT),
    .en      (state_r == ST_INIT),
    .limit   (init_limit),
    .done    (init_done)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        // low power request holds off init
        if (lp_req) begin
          state_nxt = ST_LOWPW;
        end else if (init_done && !in_reset_r) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (in_reset_r) begin
          state_nxt = ST_INIT;
        end else if (lp_req) begin
          state_nxt = ST_LOWPW;
        end
      end
      ST_LOWPW: begin
        if (!lp_req) begin
          state_nxt = ST_INIT;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // first init after power-on or reset is the long one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else if (in_reset_r) begin
      wake_r <= 1'b0;
    end else if (state_r == ST_LOWPW) begin
      wake_r <= 1'b1;
    end else if (state_r == ST_READY) begin
      wake_r <= 1'b0;
    end
  end

  // low power taken one edge after request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_mode <= 1'b0;
    end else begin
      low_power_mode <= (state_nxt == ST_LOWPW);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dnr_r <= 1'b1;
    end else if (state_nxt == ST_READY) begin
      dnr_r <= 1'b0;
    end else begin
      dnr_r <= 1'b1;
    end
  end

  // ready event interrupts; status read clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_evt_r <= 1'b0;
    end else if (state_r == ST_INIT && state_nxt == ST_READY) begin
      ready_evt_r <= 1'b1;
    end else if (rd_acc && idx == mmt_pkg::IDX_STATUS) begin
      ready_evt_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fully_functional <= 1'b0;
    end else begin
      fully_functional <= (state_nxt == ST_READY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin and bus readiness

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request_n <= 1'b1;
    end else begin
      interrupt_request_n <= !(pending || ready_evt_r);
    end
  end

  // bus ready one edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_ready <= 1'b0;
    end else begin
      serial_ready <= 1'b1;
    end
  end

endmodule : mmt_ctrl
`default_nettype wire

// ==== logic/mmt_pkg.sv ====
// constants and types shared by the module management timing block
`default_nettype none
package mmt_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CNT_W        = 26;
  localparam int unsigned IDX_W        = 8;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned NUM_FLAG_B   = 7;

  // printed times, in their own units
  localparam int unsigned T_INIT_MS    = 2000;
  localparam int unsigned T_RST_US     = 2;
  localparam int unsigned T_SERIAL_MS  = 2000;
  localparam int unsigned T_LP_ON_US   = 100;
  localparam int unsigned T_LP_OFF_MS  = 300;
  localparam int unsigned T_INT_ON_MS  = 200;
  localparam int unsigned T_INT_OFF_US = 500;
  localparam int unsigned T_LOS_MS     = 100;
  localparam int unsigned T_MASK_MS    = 100;
  localparam int unsigned T_RATE_US    = 100;
  localparam int unsigned T_PD_ON_MS   = 100;
  localparam int unsigned T_PD_OFF_MS  = 300;

  // least reset pulse rounds up; longest waits round down
  localparam int unsigned RST_PULSE_CYC =
    (T_RST_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned INIT_LIMIT_CYC = T_INIT_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_LIMIT_CYC = T_LP_OFF_MS * (CLK_HZ / 1000);

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ID       = 8'h00;
  localparam logic [7:0] IDX_STATUS   = 8'h02;
  localparam logic [7:0] IDX_FLAG_LO  = 8'h03;
  localparam logic [7:0] IDX_RATE     = 8'h57;
  localparam logic [7:0] IDX_PWR      = 8'h5d;
  localparam logic [7:0] IDX_MASK_LO  = 8'h64;
  localparam logic [7:0] IDX_PAGE     = 8'h7f;

  localparam int unsigned STAT_DNR_BIT = 0;
  localparam int unsigned STAT_LP_BIT  = 1;
  localparam int unsigned PWR_PD_BIT   = 1;

  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [7:0] RATE_RST     = 8'h00;
  localparam logic [7:0] PAGE_RST     = 8'h00;

  typedef struct packed {
    logic       pdown;
    logic [7:0] rate;
  } mmt_ctrl_t;

endpackage : mmt_pkg
`default_nettype wire

// ==== logic/mmt_timer.sv ====
// up counter with clear, enable and a reached-limit level
`timescale 1ns/100ps
`default_nettype none
module mmt_timer #(
  parameter int unsigned W = mmt_pkg::CNT_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] cnt_r;

  assign done = (cnt_r >= limit);

  // stops at the limit so it never wraps back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clr) begin
      cnt_r <= '0;
    end else if (en && !done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : mmt_timer
`default_nettype wire

// ==== logic/mmt_flags.sv ====
// latched clear-on-read flags with mask gating
`timescale 1ns/100ps
`default_nettype none
module mmt_flags #(
  parameter int unsigned N = mmt_pkg::NUM_FLAG_B * mmt_pkg::BYTE_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] cond,
  input  wire logic [N-1:0] clr,
  input  wire logic [N-1:0] mask,
  output logic [N-1:0]      flags,
  output logic              pending
);

  logic [N-1:0] cond_d_r;
  logic [N-1:0] enter;

  // only entering a condition sets a flag
  assign enter = cond & ~cond_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_d_r <= '0;
    end else begin
      cond_d_r <= cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr) | enter;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else begin
      pending <= |(flags & ~mask);
    end
  end

endmodule : mmt_flags
`default_nettype wire

// ==== tb/mmt_ctrl_assertions.sv ====
// port checker for the management timing block
`timescale 1ns/100ps
`default_nettype none
module mmt_ctrl_assertions #(
  parameter int unsigned ADDR_W    = 10,
  parameter int unsigned INIT_WAIT = 50,
  parameter int unsigned WAKE_WAIT = 30
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire logic              module_reset_n,
  input wire logic              low_power_request,
  input wire logic              interrupt_request_n,
  input wire logic              low_power_mode,
  input wire logic              fully_functional,
  input wire logic              serial_ready,
  input wire logic [7:0]        rate_select
);
  // slack of a few edges over the counted waits
  localparam int INIT_MAX = INIT_WAIT + 4;
  localparam int WAKE_MAX = WAKE_WAIT + 4;
  wire logic [7:0] acc_idx = paddr[9:2];
  wire logic       wr_acc  = psel && penable && pwrite && pstrb[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  chk_serial_up: assert property (
    $past(presetn) |-> serial_ready) else $error("bus not ready");
  chk_init_power: assert property (
    $rose(presetn) |-> ##[1:INIT_MAX] fully_functional)
    else $error("init too slow");
  chk_init_pin: assert property (
    $rose(module_reset_n) && !low_power_request
      |-> ##[1:INIT_MAX] fully_functional) else $error("pin init slow");
  chk_ready_irq: assert property (
    $rose(fully_functional) |=> !interrupt_request_n)
    else $error("no ready interrupt");
  chk_lp_enter: assert property (
    low_power_request |=> low_power_mode) else $error("low power late");
  chk_lp_wake: assert property (
    $fell(low_power_mode) |-> ##[1:WAKE_MAX] fully_functional)
    else $error("wake too slow");
  chk_pd_enter: assert property (
    wr_acc && acc_idx == mmt_pkg::IDX_PWR && pwdata[mmt_pkg::PWR_PD_BIT]
      |-> ##[1:3] low_power_mode) else $error("power down late");
  chk_rate_follow: assert property (
    wr_acc && acc_idx == mmt_pkg::IDX_RATE
      |=> ##1 rate_select == $past(pwdata[7:0], 2))
    else $error("rate not applied");
  chk_bad_index: assert property (
    psel && !penable && acc_idx == 8'h01 |=> pslverr)
    else $error("hole not refused");
endmodule : mmt_ctrl_assertions
bind mmt_ctrl mmt_ctrl_assertions #(.ADDR_W(ADDR_W), .INIT_WAIT(INIT_WAIT),
  .WAKE_WAIT(WAKE_WAIT)) chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .module_reset_n(module_reset_n), .low_power_request(low_power_request),
  .interrupt_request_n(interrupt_request_n),
  .low_power_mode(low_power_mode), .fully_functional(fully_functional),
  .serial_ready(serial_ready), .rate_select(rate_select));
`default_nettype wire

// ==== tb/mmt_host_model.sv ====
// host side model: apb master and control pins
`timescale 1ns/100ps
`default_nettype none
module mmt_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic [9:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  output logic             module_reset_n,
  output logic             low_power_request
);
  int hang;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    module_reset_n = 1'b1;
    low_power_request = 1'b0;
    hang = 0;
  end
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] d, output logic [31:0] rdat,
                      output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) hang++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines show no stale value
    pwdata <= ~pwdata;
  endtask : xfer
  task automatic pin_low(input int n);
    @(posedge pclk);
    module_reset_n <= 1'b0;
    repeat (n) @(posedge pclk);
    module_reset_n <= 1'b1;
  endtask : pin_low
  task automatic set_lp(input logic v);
    @(posedge pclk);
    low_power_request <= v;
  endtask : set_lp
endmodule : mmt_host_model
`default_nettype wire

// ==== tb/mmt_ctrl_bench.sv ====
// self-checking bench for the management timing block
`timescale 1ns/100ps
`default_nettype none
module mmt_ctrl_bench;
  localparam int INIT = 50;
  localparam int WAKE = 30;
  logic pclk, presetn, pready, pslverr, psel, penable, pwrite, err;
  logic rst_n, lp_req, irq_n, lpm, ff, ser_rdy;
  logic [3:0] rx_los, tx_fault, pstrb;
  logic [47:0] other_cond;
  logic [31:0] prdata, pwdata, rdat;
  logic [9:0] paddr;
  logic [7:0] rate;
  int bad_count, check_count;
  mmt_ctrl #(.INIT_WAIT(INIT), .WAKE_WAIT(WAKE)) dut_u (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .module_reset_n(rst_n),
    .low_power_request(lp_req), .rx_los(rx_los), .tx_fault(tx_fault),
    .other_cond(other_cond), .interrupt_request_n(irq_n),
    .low_power_mode(lpm), .fully_functional(ff), .serial_ready(ser_rdy),
    .rate_select(rate));
  mmt_host_model host_u (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .module_reset_n(rst_n), .low_power_request(lp_req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rd(input string what, input logic [7:0] i,
                    input logic [31:0] e);
    host_u.xfer(1'b0, i, 8'h00, rdat, err);
    // a bus that never answered ends the run
    if (host_u.hang != 0) close_out;
    chk(what, e, rdat);
  endtask : rd
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host_u.xfer(1'b1, i, d, rdat, err);
    if (host_u.hang != 0) close_out;
  endtask : wr
  // 0 irq_n, 1 fully_functional, 2 low_power_mode
  task automatic wait_on(input int w, input logic v, input int n);
    logic s;
    for (int k = 0; k <= n; k++) begin
      s = (w == 0) ? irq_n : (w == 1) ? ff : lpm;
      if (s === v) break;
      @(posedge pclk);
    end
    chk(w == 0 ? "irq_n" : w == 1 ? "ready" : "low_pwr", {31'h0, v},
        {31'h0, s});
    // a wait that ran out ends the run
    if (s !== v) close_out;
  endtask : wait_on
  task automatic t_start;
    wait_on(1, 1'b1, INIT + 5);
    chk("ser_rdy", 32'h1, {31'h0, ser_rdy});
    wait_on(0, 1'b0, 4);
    rd("status", mmt_pkg::IDX_STATUS, 32'h0);
    wait_on(0, 1'b1, 6);
    rd("hole", 8'h01, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("start done");
  endtask : t_start
  task automatic t_flag(input logic [55:0] v, input logic [7:0] i,
                        input logic [7:0] e);
    @(posedge pclk);
    {other_cond, tx_fault, rx_los} <= v;
    wait_on(0, 1'b0, 6);
    {other_cond, tx_fault, rx_los} <= '0;
    repeat (3) @(posedge pclk);
    rd("flag", i, {24'h0, e});
    wait_on(0, 1'b1, 6);
    rd("flag_clr", i, 32'h0);
    $display("flag done");
  endtask : t_flag
  task automatic t_mask;
    wr(8'h64, 8'h01);
    rd("mask", 8'h64, 32'h1);
    @(posedge pclk);
    rx_los <= 4'h1;
    @(posedge pclk);
    rx_los <= 4'h0;
    repeat (8) @(posedge pclk);
    chk("masked", 32'h1, {31'h0, irq_n});
    wr(8'h64, 8'h00);
    wait_on(0, 1'b0, 6);
    rd("flag", 8'h03, 32'h1);
    wait_on(0, 1'b1, 6);
    $display("mask done");
  endtask : t_mask
  task automatic t_power(input bit pin);
    if (pin) host_u.set_lp(1'b1);
    else wr(mmt_pkg::IDX_PWR, 8'h02);
    wait_on(2, 1'b1, 4);
    host_u.xfer(1'b0, mmt_pkg::IDX_STATUS, 8'h00, rdat, err);
    chk("lp_bit", 32'h1, {31'h0, rdat[1]});
    if (pin) host_u.set_lp(1'b0);
    else wr(mmt_pkg::IDX_PWR, 8'h00);
    wait_on(1, 1'b1, WAKE + 6);
    wait_on(0, 1'b0, 4);
    rd("status", mmt_pkg::IDX_STATUS, 32'h0);
    wait_on(0, 1'b1, 6);
    $display("power done");
  endtask : t_power
  task automatic t_rate;
    wr(mmt_pkg::IDX_RATE, 8'ha5);
    repeat (2) @(posedge pclk);
    chk("rate", 32'ha5, {24'h0, rate});
    // page byte is plain storage
    wr(mmt_pkg::IDX_PAGE, 8'h03);
    rd("page", mmt_pkg::IDX_PAGE, 32'h3);
    $display("rate done");
  endtask : t_rate
  task automatic t_pin;
    host_u.pin_low(10);
    repeat (4) @(posedge pclk);
    chk("short_pulse", 32'h1, {31'h0, ff});
    host_u.pin_low(45);
    chk("long_pulse", 32'h0, {31'h0, ff});
    wait_on(1, 1'b1, INIT + 5);
    rd("status", mmt_pkg::IDX_STATUS, 32'h0);
    $display("pin done");
  endtask : t_pin
  task automatic close_out;
    bad_count += host_u.hang;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, rx_los, tx_fault, other_cond} = '0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_start;
    t_flag(56'h2, 8'h03, 8'h02);
    t_flag(56'h40, 8'h03, 8'h40);
    t_flag(56'h100, 8'h04, 8'h01);
    t_mask;
    t_power(1'b1);
    t_power(1'b0);
    t_rate;
    t_pin;
    close_out;
  end
endmodule : mmt_ctrl_bench
`default_nettype wire
